//--- src/down_counter_core.sv
// Down counter core: prioritised control, count register and terminal flag
`timescale 1ns/1ps
module down_counter_core
	import down_counter_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Controls and jam word
	input ctrl_t ctl,
	input wire logic [COUNT_W-1:0] load_value,
	// Results
	output logic [COUNT_W-1:0] count_r,
	output logic zero_flag_n_r,
	output logic wrap_r,
	output logic loaded_r
);

	logic [COUNT_W-1:0] count_nxt;
	logic wrap_nxt;

	// Priority: clear, async load, sync load, count
	always_comb begin
		count_nxt = count_r;
		wrap_nxt = 1'b0;
		// [RULE8] fixed control precedence
		if (!ctl.master_clear_n) begin
			// [RULE6] clear to maximum
			count_nxt = COUNT_MAX;
		end else if (!ctl.async_load_n) begin
			// [RULE5] level load overrides sync load and count
			count_nxt = load_value;
		end else if (!ctl.sync_load_n) begin
			// [RULE4] load ignores enable
			count_nxt = load_value;
		end else if (!ctl.count_enable_n) begin
			// [RULE1] decrement by one
			count_nxt = count_r - 8'h01;
			// [RULE7] zero wraps to 255
			wrap_nxt = (count_r == COUNT_ZERO);
		end
		// [RULE2] disabled count holds
	end

	// Count register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= COUNT_RESET;
		end else begin
			count_r <= count_nxt;
		end
	end

	// Terminal flag, low for one period at zero while enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zero_flag_n_r <= 1'b1;
		end else begin
			// [RULE3] flag zero while enabled
			zero_flag_n_r <= !((count_nxt == COUNT_ZERO) && !ctl.count_enable_n);
		end
	end

	// Event pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wrap_r <= 1'b0;
			loaded_r <= 1'b0;
		end else begin
			wrap_r <= wrap_nxt;
			loaded_r <= ctl.master_clear_n && !(ctl.async_load_n && ctl.sync_load_n);
		end
	end

endmodule : down_counter_core

//--- src/down_counter_pkg.sv
// Package: register map, field layout, reset values and control carrier for the down counter
package down_counter_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int COUNT_W = 8;
	localparam int WRAPS_W = 16;
	localparam int ADDR_W = 8;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_LOAD = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_WRAPS = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_PINS = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h18;

	// ************************************************************
	// Field positions
	// ************************************************************
	// Control register, all active low, same order as ctrl_t
	localparam int CTRL_CLEAR_BIT = 3;
	localparam int CTRL_ALOAD_BIT = 2;
	localparam int CTRL_SLOAD_BIT = 1;
	localparam int CTRL_ENABLE_BIT = 0;
	// Status register
	localparam int STAT_ZERO_BIT = 0;
	localparam int STAT_WRAP_BIT = 1;
	localparam int STAT_LOADED_BIT = 2;
	// Command register, write one to pulse
	localparam int CMD_CLEAR_BIT = 0;
	localparam int CMD_SLOAD_BIT = 1;

	// ************************************************************
	// Values after reset and fixed counts
	// ************************************************************
	localparam logic [COUNT_W-1:0] COUNT_MAX = 8'hff;
	localparam logic [COUNT_W-1:0] COUNT_ZERO = 8'h00;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 8'hff;
	localparam logic [COUNT_W-1:0] LOAD_RESET = 8'h00;
	localparam logic [3:0] CTRL_RESET = 4'hf;
	localparam logic [WRAPS_W-1:0] WRAPS_RESET = 16'h0000;

	// ************************************************************
	// Control carrier, every field active low
	// ************************************************************
	typedef struct packed {
		logic master_clear_n;
		logic async_load_n;
		logic sync_load_n;
		logic count_enable_n;
	} ctrl_t;

	localparam ctrl_t CTRL_IDLE = 4'hf;

endpackage : down_counter_pkg

//--- src/down_counter_top.sv
// Top: 8-bit down counter with pin controls and an APB register slave
//
// Operation
// [RULE1] Eight-bit count decreases by one per enabled clock edge without load or clear.
// [RULE2] Count enable high keeps the count unchanged unless a load or clear acts.
// [RULE3] Zero flag low while count is zero and enable low, one clock period.
// [RULE4] Synchronous load low captures the load value next edge, regardless of enable.
// [RULE5] Asynchronous load low forces the load value, ignoring sync load and enable.
// [RULE6] Master clear low sets the count to 255, overriding every other input.
// [RULE7] Enabled count at zero wraps to 255, giving a 256 clock cycle.
// [RULE8] Priority: clear, asynchronous load, synchronous load, then count enable.
// [RULE9] Load value is one unsigned word, bit 7 most significant, bit 0 least.
// [RULE10] All controls and the zero flag are active low; low asserts.
// [RULE11] Cascading routes each stage's zero flag into the next stage's enable.
`timescale 1ns/1ps
module down_counter_top
	import down_counter_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Counter control pins
	input wire logic master_clear_n,
	input wire logic async_load_n,
	input wire logic sync_load_n,
	input wire logic count_enable_n,
	input wire logic [COUNT_W-1:0] load_value,
	// Counter outputs
	output logic zero_flag_n,
	output logic [COUNT_W-1:0] count_value
);

	// ************************************************************
	// Declarations
	// ************************************************************
	ctrl_t sw_ctrl_r;
	logic [COUNT_W-1:0] sw_load_r;
	logic [WRAPS_W-1:0] wraps_r;
	logic wrap_flag_r;
	logic loaded_flag_r;
	logic cmd_clear_r;
	logic cmd_sload_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic [31:0] rdata_nxt;
	logic addr_ok;
	logic access;
	logic wr_en;
	logic rd_en;
	ctrl_t pin_ctrl;
	ctrl_t eff_ctrl;
	logic [COUNT_W-1:0] eff_load;
	logic [COUNT_W-1:0] core_count;
	logic core_zero_n;
	logic core_wrap;
	logic core_loaded;

	// ************************************************************
	// APB decode
	// ************************************************************

	// Access phase, taken on the first access cycle
	assign access = psel && penable && !pready_r;
	assign wr_en = access && pwrite && addr_ok;
	assign rd_en = access && !pwrite;

	// Address map check
	always_comb begin
		unique case (paddr)
			ADDR_CTRL, ADDR_LOAD, ADDR_COUNT, ADDR_STATUS,
			ADDR_WRAPS, ADDR_PINS, ADDR_CMD: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// ************************************************************
	// Control merging
	// ************************************************************

	// Pin controls gathered into the carrier
	assign pin_ctrl.master_clear_n = master_clear_n;
	assign pin_ctrl.async_load_n = async_load_n;
	assign pin_ctrl.sync_load_n = sync_load_n;
	assign pin_ctrl.count_enable_n = count_enable_n;

	// [RULE10] active low, either source asserts
	assign eff_ctrl.master_clear_n = pin_ctrl.master_clear_n && sw_ctrl_r.master_clear_n
		&& !cmd_clear_r;
	assign eff_ctrl.async_load_n = pin_ctrl.async_load_n && sw_ctrl_r.async_load_n;
	assign eff_ctrl.sync_load_n = pin_ctrl.sync_load_n && sw_ctrl_r.sync_load_n
		&& !cmd_sload_r;
	// [RULE11] enable pin accepts cascade flag
	assign eff_ctrl.count_enable_n = pin_ctrl.count_enable_n && sw_ctrl_r.count_enable_n;

	// Jam word: pins when a pin load asserts, else software word
	// [RULE9] bit 7 most significant
	assign eff_load = (!async_load_n || !sync_load_n) ? load_value[7:0] : sw_load_r[7:0];

	// ************************************************************
	// Counter core
	// ************************************************************

	down_counter_core u_core (
		.pclk(pclk),
		.presetn(presetn),
		.ctl(eff_ctrl),
		.load_value(eff_load),
		.count_r(core_count),
		.zero_flag_n_r(core_zero_n),
		.wrap_r(core_wrap),
		.loaded_r(core_loaded)
	);

	// ************************************************************
	// Output flops
	// ************************************************************

	// Pin outputs follow core flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zero_flag_n <= 1'b1;
			count_value <= COUNT_RESET;
		end else begin
			// [RULE3] flag to pin
			zero_flag_n <= core_zero_n;
			count_value <= core_count;
		end
	end

	// ************************************************************
	// Software registers
	// ************************************************************

	// Control register, steers the counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_ctrl_r <= CTRL_IDLE;
		end else if (wr_en && paddr == ADDR_CTRL) begin
			sw_ctrl_r.master_clear_n <= pwdata[CTRL_CLEAR_BIT];
			sw_ctrl_r.async_load_n <= pwdata[CTRL_ALOAD_BIT];
			sw_ctrl_r.sync_load_n <= pwdata[CTRL_SLOAD_BIT];
			sw_ctrl_r.count_enable_n <= pwdata[CTRL_ENABLE_BIT];
		end
	end

	// Software jam word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_load_r <= LOAD_RESET;
		end else if (wr_en && paddr == ADDR_LOAD) begin
			sw_load_r <= pwdata[COUNT_W-1:0];
		end
	end

	// One-cycle command pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_clear_r <= 1'b0;
			cmd_sload_r <= 1'b0;
		end else begin
			cmd_clear_r <= wr_en && paddr == ADDR_CMD && pwdata[CMD_CLEAR_BIT];
			cmd_sload_r <= wr_en && paddr == ADDR_CMD && pwdata[CMD_SLOAD_BIT];
		end
	end

	// ************************************************************
	// Event tracking
	// ************************************************************

	// Wrap sticky flag, set wins over write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wrap_flag_r <= 1'b0;
		end else if (core_wrap) begin
			// [RULE7] wrap seen
			wrap_flag_r <= 1'b1;
		end else if (wr_en && paddr == ADDR_STATUS && pwdata[STAT_WRAP_BIT]) begin
			wrap_flag_r <= 1'b0;
		end
	end

	// Load sticky flag, set wins over write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loaded_flag_r <= 1'b0;
		end else if (core_loaded) begin
			loaded_flag_r <= 1'b1;
		end else if (wr_en && paddr == ADDR_STATUS && pwdata[STAT_LOADED_BIT]) begin
			loaded_flag_r <= 1'b0;
		end
	end

	// Wrap counter, any write clears, wrap in same cycle counts as one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wraps_r <= WRAPS_RESET;
		end else if (wr_en && paddr == ADDR_WRAPS) begin
			wraps_r <= core_wrap ? 16'h0001 : WRAPS_RESET;
		end else if (core_wrap) begin
			wraps_r <= wraps_r + 16'h0001;
		end
	end

	// ************************************************************
	// Read data
	// ************************************************************

	// Read mux, reserved bits zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		unique case (paddr)
			ADDR_CTRL: begin
				rdata_nxt[CTRL_CLEAR_BIT] = sw_ctrl_r.master_clear_n;
				rdata_nxt[CTRL_ALOAD_BIT] = sw_ctrl_r.async_load_n;
				rdata_nxt[CTRL_SLOAD_BIT] = sw_ctrl_r.sync_load_n;
				rdata_nxt[CTRL_ENABLE_BIT] = sw_ctrl_r.count_enable_n;
			end
			ADDR_LOAD: rdata_nxt[COUNT_W-1:0] = sw_load_r;
			ADDR_COUNT: rdata_nxt[COUNT_W-1:0] = core_count;
			ADDR_STATUS: begin
				rdata_nxt[STAT_ZERO_BIT] = core_zero_n;
				rdata_nxt[STAT_WRAP_BIT] = wrap_flag_r;
				rdata_nxt[STAT_LOADED_BIT] = loaded_flag_r;
			end
			ADDR_WRAPS: rdata_nxt[WRAPS_W-1:0] = wraps_r;
			ADDR_PINS: begin
				rdata_nxt[COUNT_W-1:0] = load_value;
				rdata_nxt[11:8] = pin_ctrl;
			end
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// ************************************************************
	// APB answer
	// ************************************************************

	// Ready pulses one cycle after the access phase opens
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= access;
			pslverr_r <= access && !addr_ok;
		end
	end

	// Read data captured with ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (rd_en && addr_ok) begin
			prdata_r <= rdata_nxt;
		end else if (access) begin
			prdata_r <= 32'h0000_0000;
		end
	end

	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign prdata = prdata_r;

endmodule : down_counter_top

//--- testbench/down_counter_chk.sv
// Checker for the down counter pins and handshake
`timescale 1ns/1ps
module down_counter_chk
	import down_counter_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB handshake
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// Counter pins
	input wire logic master_clear_n,
	input wire logic async_load_n,
	input wire logic sync_load_n,
	input wire logic count_enable_n,
	input wire logic [COUNT_W-1:0] load_value,
	input wire logic zero_flag_n,
	input wire logic [COUNT_W-1:0] count_value
);
	// ****
	// Helpers
	// ****
	logic [1:0] warm_r;
	logic [3:0] pins;
	logic ok;
	// Edges since reset, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warm_r <= 2'h0;
		end else if (!ok) begin
			warm_r <= warm_r + 2'h1;
		end
	end
	// Pins in priority order
	assign pins = {master_clear_n, async_load_n, sync_load_n, count_enable_n};
	assign ok = warm_r == 2'h3;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****
	// Assertions
	// ****
	AST_COUNT_DOWN:
	assert property (ok && $past(pins, 2) == 4'he |-> count_value == $past(count_value) - 8'h01)
		else $error("count missed a step");
	AST_HOLD:
	assert property (ok && $past(pins, 2) == 4'hf |-> $stable(count_value))
		else $error("count moved while inhibited");
	AST_SYNC_LOAD:
	assert property (ok && $past(pins[3:1], 2) == 3'h6 |-> count_value == $past(load_value, 2))
		else $error("sync load missed");
	AST_ASYNC_LOAD:
	assert property (ok && $past(pins[3:2], 2) == 2'h2 |-> count_value == $past(load_value, 2))
		else $error("async load missed");
	AST_CLEAR:
	assert property (ok && !$past(master_clear_n, 2) |-> count_value == COUNT_MAX)
		else $error("clear missed");
	AST_ZERO_FLAG:
	assert property (ok |-> zero_flag_n == !(count_value == COUNT_ZERO && !$past(count_enable_n, 2)))
		else $error("zero flag wrong");
	AST_ZERO_PULSE:
	assert property (!zero_flag_n && $past(pins) == 4'he |=> zero_flag_n)
		else $error("zero flag too long");
	AST_WRAP:
	assert property (ok && $past(pins, 2) == 4'he && $past(count_value) == COUNT_ZERO
		|-> count_value == COUNT_MAX)
		else $error("no wrap to maximum");
	AST_APB_ANSWER:
	assert property (psel && penable && !pready |=> pready)
		else $error("no answer");
	// Main scenarios
	cover property (!zero_flag_n);
	cover property (ok && $past(pins, 2) == 4'he && $past(count_value) == COUNT_ZERO);
	cover property (ok && $past(pins[3:2], 2) == 2'h2);
endmodule : down_counter_chk

bind down_counter_top down_counter_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .master_clear_n(master_clear_n),
	.async_load_n(async_load_n), .sync_load_n(sync_load_n), .count_enable_n(count_enable_n),
	.load_value(load_value), .zero_flag_n(zero_flag_n), .count_value(count_value));

//--- testbench/down_counter_ctl.sv
// Control logic model driving the counter pins
`timescale 1ns/1ps
module down_counter_ctl
	import down_counter_pkg::*;
(
	// Clock
	input wire logic pclk,
	// Pins toward the counter
	output ctrl_t ctl,
	output logic [COUNT_W-1:0] load_value
);
	ctrl_t ctl_r;
	logic cascade_r;
	logic [1:0] stage_r;
	// All controls released
	initial begin
		ctl_r = CTRL_IDLE;
		load_value = 8'h00;
		cascade_r = 1'b0;
		stage_r = 2'h0;
	end
	// Upstream stage, flag low one clock in four
	always @(posedge pclk) begin
		stage_r <= stage_r + 2'h1;
	end
	assign ctl = {ctl_r[3:1], (cascade_r ? (stage_r != 2'h0) : ctl_r.count_enable_n)};
	// Hold controls for n sampling edges
	task apply(input logic [3:0] c, input logic [COUNT_W-1:0] v, input int n);
		ctl_r <= c;
		load_value <= v;
		repeat (n) @(posedge pclk);
	endtask : apply
endmodule : down_counter_ctl

//--- testbench/down_counter_top_tb.sv
// Testbench for the down counter top
`timescale 1ns/1ps
module down_counter_top_tb
	import down_counter_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, zero_flag_n;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [COUNT_W-1:0] load_value, count_value, v0;
	ctrl_t ctl;
	int checks, failures;

	down_counter_ctl p (.pclk(pclk), .ctl(ctl), .load_value(load_value));
	down_counter_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .master_clear_n(ctl.master_clear_n), .async_load_n(ctl.async_load_n),
		.sync_load_n(ctl.sync_load_n), .count_enable_n(ctl.count_enable_n),
		.load_value(load_value), .zero_flag_n(zero_flag_n), .count_value(count_value));

	// 200 MHz clock
	always #2.5 pclk = ~pclk;

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			failures++;
			$display("ERROR %0t no answer", $time);
			end_of_test;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task settle;
		p.apply(CTRL_IDLE, 8'h00, 2);
	endtask : settle

	task t_reset;
		cmp(count_value, COUNT_MAX);
		cmp(zero_flag_n, 1'b1);
		apb(1'b0, ADDR_CTRL, 0);
		cmp(q, 32'hf);
	endtask : t_reset

	task t_count;
		int lows;
		p.apply(4'hc, 8'h03, 1);
		p.apply(CTRL_IDLE, 8'h00, 4);
		cmp(count_value, 8'h03);
		lows = 0;
		repeat (5) begin
			p.apply(4'he, 8'h00, 1);
			lows += (zero_flag_n === 1'b0);
		end
		settle;
		cmp(count_value, 8'hfe);
		cmp(lows, 1);
		p.apply(4'he, 8'h00, 256);
		settle;
		cmp(count_value, 8'hfe);
	endtask : t_count

	task t_prio;
		logic [3:0] cs[7];
		logic [7:0] ex[7];
		cs = '{4'h0, 4'h7, 4'h8, 4'hb, 4'hc, 4'he, 4'hf};
		ex = '{8'hff, 8'hff, 8'h81, 8'h81, 8'h81, 8'h0f, 8'h10};
		foreach (cs[i]) begin
			p.apply(4'hd, 8'h10, 1);
			p.apply(cs[i], 8'h81, 1);
			settle;
			cmp(count_value, ex[i]);
		end
		p.apply(4'hd, 8'h80, 1);
		p.apply(4'he, 8'h00, 1);
		settle;
		cmp(count_value, 8'h7f);
	endtask : t_prio

	task t_apb;
		apb(1'b1, ADDR_LOAD, 32'h5a);
		apb(1'b0, ADDR_LOAD, 0);
		cmp(q, 32'h5a);
		apb(1'b0, ADDR_PINS, 0);
		cmp(q, 32'hf00);
		apb(1'b1, 8'h40, 32'h1);
		cmp(e, 1'b1);
		apb(1'b0, ADDR_COUNT, 0);
		cmp(q, 32'h7f);
	endtask : t_apb

	// Wrap count, sticky flags and their clears; two wraps happened in t_count
	task t_regs;
		apb(1'b0, ADDR_WRAPS, 0);
		cmp(q, 32'h2);
		apb(1'b0, ADDR_STATUS, 0);
		cmp(q, 32'h7);
		apb(1'b1, ADDR_STATUS, 32'h6);
		apb(1'b0, ADDR_STATUS, 0);
		cmp(q, 32'h1);
		apb(1'b1, ADDR_WRAPS, 32'h0);
		apb(1'b0, ADDR_WRAPS, 0);
		cmp(q, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'hf);
		apb(1'b0, ADDR_CTRL, 0);
		cmp(q, 32'hf);
		apb(1'b0, ADDR_COUNT, 0);
		cmp(q, 32'h7f);
	endtask : t_regs

	task t_cascade;
		p.cascade_r <= 1'b1;
		p.apply(CTRL_IDLE, 8'h00, 4);
		v0 = count_value;
		p.apply(CTRL_IDLE, 8'h00, 16);
		cmp(8'(v0 - count_value), 8'h04);
		p.cascade_r <= 1'b0;
	endtask : t_cascade

	task end_of_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test

	// Reset, then the scenarios
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		checks = 0;
		failures = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_count;
		t_prio;
		t_apb;
		t_regs;
		t_cascade;
		end_of_test;
	end

	// Watchdog
	initial begin
		#20000;
		failures++;
		end_of_test;
	end
endmodule : down_counter_top_tb
